// ### design/sbcsc_clock_gate.sv
`timescale 1ns/100ps
`default_nettype none
module sbcsc_clock_gate (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic phaseNow,
  input wire logic phaseNext,
  input wire logic enable,
  output logic gatedClk
);
  logic enHeld;
  logic next_enHeld;
  logic next_gatedClk;
  always_comb begin
    // Enable is only taken while the clock is low, so no pulse is cut short
    next_enHeld = phaseNow ? enHeld : enable;
    next_gatedClk = phaseNext & next_enHeld;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enHeld <= 1'b0;
      gatedClk <= 1'b0;
    end else begin
      enHeld <= next_enHeld;
      gatedClk <= next_gatedClk;
    end
  end
  gate_rise_a: assert property (@(posedge sys_clk) disable iff (srst) $rose(gatedClk) |-> $rose(phaseNow))
    else $error("gated clock rose outside phase edge");
  gate_fall_a: assert property (@(posedge sys_clk) disable iff (srst) $fell(gatedClk) |-> $fell(phaseNow))
    else $error("gated clock pulse truncated");
endmodule
`default_nettype wire

// ### design/sbcsc_cnt_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sbcsc_cnt_if;
  logic clear;
  logic run;
  logic [11:0] count;
  modport ctl (output clear, output run, input count);
  modport cnt (input clear, input run, output count);
endinterface
`default_nettype wire

// ### design/sbcsc_delay_counter.sv
`timescale 1ns/100ps
`default_nettype none
module sbcsc_delay_counter (
  input wire logic sys_clk,
  input wire logic srst,
  sbcsc_cnt_if.cnt cnt
);
  import sbcsc_pkg::*;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  always_comb begin
    next_count = count;
    if (cnt.clear) begin
      next_count = '0;
    end else if (cnt.run) begin
      next_count = count + 12'h001;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
  assign cnt.count = count;
  cnt_clear_a: assert property (@(posedge sys_clk) disable iff (srst) cnt.clear |=> count == 12'h000)
    else $error("delay counter not cleared");
  cnt_step_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!cnt.clear && cnt.run) |=> count == $past(count) + 12'h001)
    else $error("delay counter did not advance");
endmodule
`default_nettype wire

// ### design/sbcsc_pkg.sv
// What this block does
// - Generator clock comes from oscillator or PLL; bus clock is half of it.
// - In user mode bus frequency is oscillator or PLL clock divided by four.
// - After power-on or low-voltage reset, clocks wait 4096 oscillator cycles.
// - The active-low reset pin is driven low during that start-up wait.
// - Bus clock starts toggling at the first generator rising edge once the start-up count completes.
// - On stop exit the oscillator clock drives the delay counter.
// - After stop exit clocks stay off until a 4096 or 32 cycle delay expires.
// - CPU clocks are held inactive in wait mode.
// - Two module clock sets, one of them optionally active in wait mode.
// - Oscillator-run-in-stop bit keeps the oscillator running in stop; reset clears it.
// - Flag register low shows flags six to one in bits 7..2, read-only, resets zero.
// - Flag register mid shows flags nine to seven in bits 2..0, read-only, resets zero.
// - Flag register high shows flags seventeen, sixteen in bits 2..1, read-only.
// - Short-stop-recovery bit set selects a 32 cycle recovery instead of 4096.
// - Delay counter is 12 bits, advances on oscillator clock, cleared by stop.
package sbcsc_pkg;
  localparam int ADDR_W = 18;
  localparam int CNT_W = 12;
  localparam logic [15:0] IDX_FLAGS_LOW = 16'hfe04;
  localparam logic [15:0] IDX_FLAGS_MID = 16'hfe05;
  localparam logic [15:0] IDX_FLAGS_HIGH = 16'hfe06;
  localparam logic [15:0] IDX_CTRL = 16'hfe08;
  localparam logic [15:0] IDX_STATE = 16'hfe09;
  localparam logic [15:0] IDX_INT_STATUS = 16'hfe0a;
  localparam logic [15:0] IDX_INT_MASK = 16'hfe0b;
  localparam int CTRL_OSC_RUN = 0;
  localparam int CTRL_SHORT_REC = 1;
  localparam int CTRL_PLL_SEL = 2;
  localparam int CTRL_MODB_WAIT = 3;
  localparam int EV_STARTUP = 0;
  localparam int EV_RECOVER = 1;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] INT_RESET = 2'h0;
  localparam logic [CNT_W-1:0] STARTUP_LAST = 12'hfff;
  localparam logic [CNT_W-1:0] LONG_REC_LAST = 12'hfff;
  localparam logic [CNT_W-1:0] SHORT_REC_LAST = 12'h01f;
  typedef enum logic [4:0] {
    ST_STARTUP = 5'b00001,
    ST_RUN = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_STOP = 5'b01000,
    ST_RECOVER = 5'b10000
  } sbcsc_state_type;
endpackage

// ### design/sbcsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module sbcsc_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [sbcsc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pllOutClk,
  input wire logic powerOnPulse,
  input wire logic lowVoltageReset,
  input wire logic stopReq,
  input wire logic waitReq,
  input wire logic wakeEvent,
  input wire logic [8:0] irqFlagLo,
  input wire logic [1:0] irqFlagHi,
  output logic genClkOut,
  output logic busClk,
  output logic cpuClk,
  output logic modClkA,
  output logic modClkB,
  output logic oscEnable,
  output logic extResetOut_n,
  output logic extResetOe,
  output logic irq
);
  import sbcsc_pkg::*;

  sbcsc_state_type state;
  sbcsc_state_type next_state;
  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  logic [1:0] intStatus;
  logic [1:0] next_intStatus;
  logic [1:0] intMask;
  logic [1:0] next_intMask;
  logic [7:0] flagsLow;
  logic [7:0] flagsMid;
  logic [7:0] flagsHigh;
  logic [7:0] next_flagsLow;
  logic [7:0] next_flagsMid;
  logic [7:0] next_flagsHigh;
  logic pllSync1;
  logic pllSync2;
  logic pllPrev;
  logic genClk;
  logic next_genClk;
  logic busPhase;
  logic next_busPhase;
  logic next_oscEnable;
  logic next_extResetOe;
  logic next_irq;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic [31:0] readMux;
  logic addrHit;
  logic access;
  logic [1:0] events;
  logic genTick;
  logic recoverDone;
  logic clocksOn;
  logic [CNT_W-1:0] count;
  logic coldReset;

  sbcsc_cnt_if cntBus ();

  sbcsc_delay_counter u_counter (
    .sys_clk(sys_clk),
    .srst(srst),
    .cnt(cntBus.cnt)
  );

  assign count = cntBus.count;
  assign coldReset = powerOnPulse | lowVoltageReset;

  // Mode state machine
  always_comb begin
    next_state = state;
    recoverDone = ctrl[CTRL_SHORT_REC] ? (count == SHORT_REC_LAST) : (count == LONG_REC_LAST);
    if (coldReset) begin
      next_state = ST_STARTUP;
    end else begin
      case (state)
        ST_STARTUP: begin
          if (count == STARTUP_LAST) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (stopReq) begin
            next_state = ST_STOP;
          end else if (waitReq) begin
            next_state = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wakeEvent) begin
            next_state = ST_RUN;
          end
        end
        ST_STOP: begin
          if (wakeEvent) begin
            next_state = ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (recoverDone) begin
            next_state = ST_RUN;
          end
        end
        default: begin
          next_state = ST_STARTUP;
        end
      endcase
    end
  end

  // Counter control: cleared on cold reset and stop entry, held in stop
  always_comb begin
    cntBus.clear = coldReset | (state == ST_RUN && stopReq);
    cntBus.run = (state != ST_STOP);
  end

  // Clock source and division
  always_comb begin
    clocksOn = (next_state == ST_RUN) || (next_state == ST_WAIT);
    genTick = ctrl[CTRL_PLL_SEL] ? (pllSync2 & ~pllPrev) : oscEnable;
    next_genClk = genTick ? ~genClk : genClk;
    // Bus phase toggles on each generator rising edge while clocks are on, else held low: source / 4 overall
    next_busPhase = 1'b0;
    if (clocksOn) begin
      next_busPhase = (genTick & ~genClk) ? ~busPhase : busPhase;
    end
    // Oscillator stops in stop mode unless software keeps it running
    next_oscEnable = (next_state != ST_STOP) | ctrl[CTRL_OSC_RUN];
    next_extResetOe = (next_state == ST_STARTUP);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pllSync1 <= 1'b0;
      pllSync2 <= 1'b0;
      pllPrev <= 1'b0;
    end else begin
      pllSync1 <= pllOutClk;
      pllSync2 <= pllSync1;
      pllPrev <= pllSync2;
    end
  end

  sbcsc_clock_gate u_cpu_gate (
    .sys_clk(sys_clk),
    .srst(srst),
    .phaseNow(busPhase),
    .phaseNext(next_busPhase),
    .enable(state == ST_RUN),
    .gatedClk(cpuClk)
  );

  sbcsc_clock_gate u_moda_gate (
    .sys_clk(sys_clk),
    .srst(srst),
    .phaseNow(busPhase),
    .phaseNext(next_busPhase),
    .enable(state == ST_RUN || state == ST_WAIT),
    .gatedClk(modClkA)
  );

  // Second set may run in wait only when software asks for it
  sbcsc_clock_gate u_modb_gate (
    .sys_clk(sys_clk),
    .srst(srst),
    .phaseNow(busPhase),
    .phaseNext(next_busPhase),
    .enable(state == ST_RUN || (state == ST_WAIT && ctrl[CTRL_MODB_WAIT])),
    .gatedClk(modClkB)
  );

  // Register bus
  always_comb begin
    addrHit = 1'b1;
    readMux = 32'h0000_0000;
    case (paddr)
      {IDX_FLAGS_LOW, 2'b00}: readMux = {24'h00_0000, flagsLow};
      {IDX_FLAGS_MID, 2'b00}: readMux = {24'h00_0000, flagsMid};
      {IDX_FLAGS_HIGH, 2'b00}: readMux = {24'h00_0000, flagsHigh};
      {IDX_CTRL, 2'b00}: readMux = {28'h000_0000, ctrl};
      {IDX_STATE, 2'b00}: readMux = {27'h000_0000, state};
      {IDX_INT_STATUS, 2'b00}: readMux = {30'h0000_0000, intStatus};
      {IDX_INT_MASK, 2'b00}: readMux = {30'h0000_0000, intMask};
      default: addrHit = 1'b0;
    endcase
    access = psel & penable & pready;
    next_pready = psel & ~penable;
    next_prdata = next_pready ? readMux : prdata;
    next_pslverr = psel & ~penable & ~addrHit;
  end

  always_comb begin
    next_ctrl = ctrl;
    next_intMask = intMask;
    events = 2'b00;
    events[EV_STARTUP] = (state == ST_STARTUP) && (next_state == ST_RUN);
    events[EV_RECOVER] = (state == ST_RECOVER) && (next_state == ST_RUN);
    next_intStatus = intStatus;
    if (access && pwrite && !pslverr) begin
      if (paddr == {IDX_CTRL, 2'b00}) begin
        next_ctrl = pwdata[3:0];
      end
      if (paddr == {IDX_INT_MASK, 2'b00}) begin
        next_intMask = pwdata[1:0];
      end
      if (paddr == {IDX_INT_STATUS, 2'b00}) begin
        next_intStatus = intStatus & ~pwdata[1:0];
      end
    end
    // An event in the clearing cycle is kept
    next_intStatus = next_intStatus | events;
    next_irq = |(next_intStatus & next_intMask);
    // Flag registers are snapshots; writes to them fall through untouched
    next_flagsLow = {irqFlagLo[5:0], 2'b00};
    next_flagsMid = {5'b0_0000, irqFlagLo[8:6]};
    next_flagsHigh = {5'b0_0000, irqFlagHi[1], irqFlagHi[0], 1'b0};
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_STARTUP;
      ctrl <= CTRL_RESET;
      intStatus <= INT_RESET;
      intMask <= INT_RESET;
      flagsLow <= 8'h00;
      flagsMid <= 8'h00;
      flagsHigh <= 8'h00;
      genClk <= 1'b0;
      busPhase <= 1'b0;
      oscEnable <= 1'b1;
      extResetOe <= 1'b1;
      irq <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      intStatus <= next_intStatus;
      intMask <= next_intMask;
      flagsLow <= next_flagsLow;
      flagsMid <= next_flagsMid;
      flagsHigh <= next_flagsHigh;
      genClk <= next_genClk;
      busPhase <= next_busPhase;
      oscEnable <= next_oscEnable;
      extResetOe <= next_extResetOe;
      irq <= next_irq;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Open-drain reset pin: only ever pulled low
  always_ff @(posedge sys_clk) begin
    extResetOut_n <= 1'b0;
  end
  assign genClkOut = genClk;
  assign busClk = busPhase;

  startup_pin_a: assert property (@(posedge sys_clk) disable iff (srst)
    extResetOe == (state == ST_STARTUP))
    else $error("reset pin drive does not follow start-up");
  startup_len_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == ST_STARTUP && !coldReset && next_state == ST_RUN) |-> count == 12'hfff)
    else $error("start-up left early");
  bus_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    !(state == ST_RUN || state == ST_WAIT) |-> !busClk)
    else $error("bus clock toggles outside run or wait");
  stop_len_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == ST_RECOVER && next_state == ST_RUN && !coldReset)
      |-> count == (ctrl[CTRL_SHORT_REC] ? 12'h01f : 12'hfff))
    else $error("stop recovery length wrong");
  stop_gated_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == ST_STOP || state == ST_RECOVER) |-> !cpuClk && !modClkA && !modClkB)
    else $error("clock active during stop or recovery");
  wait_cpu_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == ST_WAIT && !busClk) |=> !cpuClk)
    else $error("CPU clock runs in wait");
  osc_stop_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == ST_STOP && $stable(ctrl)) |-> oscEnable == ctrl[CTRL_OSC_RUN])
    else $error("oscillator enable wrong in stop");
  // The first edge after reset has no toggle behind it, since the previous edge was a reset edge
  gen_div_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!$past(srst) && !ctrl[CTRL_PLL_SEL] && $past(!ctrl[CTRL_PLL_SEL]) && $past(oscEnable))
      |-> genClk != $past(genClk))
    else $error("generator clock not half oscillator");
  bus_div_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == ST_RUN && !ctrl[CTRL_PLL_SEL] && oscEnable) [*4] |-> busClk != $past(busClk, 2))
    else $error("bus clock not oscillator over four");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (srst)
    irq == |(intStatus & intMask))
    else $error("interrupt level mismatch");
endmodule
`default_nettype wire

// ### dv/sbcsc_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sbcsc_bench;
  import sbcsc_pkg::*;
  logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pllOutClk = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h0000_0005, rd, lo;
  logic pready, pslverr, genClkOut, busClk, cpuClk, modClkA, modClkB, oscEnable, extResetOut_n, extResetOe, irq, err;
  logic powerOnPulse = 0, lowVoltageReset = 0, stopReq = 0, waitReq = 0, wakeEvent = 0;
  logic [8:0] irqFlagLo = '0;
  logic [1:0] irqFlagHi = '0;
  int num_errors = 0, tests_run = 0, cpuE, modAE, modBE, n, pllDiv = 0, c, a, b;
  always #20 sys_clk = ~sys_clk;
  // Slow PLL stand-in: six sys_clk cycles a period
  always @(posedge sys_clk) begin
    pllDiv <= (pllDiv == 2) ? 0 : pllDiv + 1;
    if (pllDiv == 2) pllOutClk <= ~pllOutClk;
  end
  sbcsc_top u_sbcsc_top (.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pllOutClk(pllOutClk), .powerOnPulse(powerOnPulse), .lowVoltageReset(lowVoltageReset),
    .stopReq(stopReq), .waitReq(waitReq), .wakeEvent(wakeEvent), .irqFlagLo(irqFlagLo),
    .irqFlagHi(irqFlagHi), .genClkOut(genClkOut), .busClk(busClk), .cpuClk(cpuClk), .modClkA(modClkA),
    .modClkB(modClkB), .oscEnable(oscEnable), .extResetOut_n(extResetOut_n), .extResetOe(extResetOe),
    .irq(irq));
  sbcsc_core_model u_sbcsc_core_model (.sys_clk(sys_clk), .cpuClk(cpuClk), .modClkA(modClkA),
    .modClkB(modClkB), .cpuEdges(cpuE), .modAEdges(modAE), .modBEdges(modBE));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] inr(input int v, input int l, input int h);
    return 32'((v >= l) && (v <= h));
  endfunction
  task automatic summarize();
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One transfer, then one idle cycle so psel is never assigned twice in a time step
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int k;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic until_clk(input bit cpu, input int lim);
    n = 0;
    while ((cpu ? cpuClk : busClk) !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic window(input int cyc);
    c = cpuE;
    a = modAE;
    b = modBE;
    repeat (cyc) @(posedge sys_clk);
    c = cpuE - c;
    a = modAE - a;
    b = modBE - b;
  endtask
  task automatic pulse(input int which);
    if (which == 0) waitReq <= 1'b1;
    if (which == 1) stopReq <= 1'b1;
    if (which == 2) wakeEvent <= 1'b1;
    if (which == 3) lowVoltageReset <= 1'b1;
    if (which == 4) powerOnPulse <= 1'b1;
    @(posedge sys_clk);
    {waitReq, stopReq, wakeEvent, lowVoltageReset, powerOnPulse} <= 5'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4000) @(posedge sys_clk);
    check("resetOe start", 32'(extResetOe), 1);
    check("cpuClk start", 32'(cpuE), 0);
    check("reset pin low", 32'(extResetOut_n), 0);
    until_clk(0, 200);
    check("startup length", inr(n + 4000, 4094, 4106), 1);
    repeat (8) @(posedge sys_clk);
    check("resetOe run", 32'(extResetOe), 0);
    check("irq masked", 32'(irq), 0);
    apb(1'b0, IDX_INT_STATUS, 0);
    check("start event", rd, 1);
    for (int i = 0; i < 6; i++) begin
      {irqFlagHi, irqFlagLo} <= 11'(rnd());
      repeat (2) @(posedge sys_clk);
      apb(1'b1, IDX_FLAGS_LOW, rnd());
      check("flag write err", {31'h0, err}, 0);
      apb(1'b0, IDX_FLAGS_LOW, 0);
      check("flags low", rd, {24'h0, irqFlagLo[5:0], 2'b00});
      apb(1'b0, IDX_FLAGS_MID, 0);
      check("flags mid", rd, {29'h0, irqFlagLo[8:6]});
      apb(1'b0, IDX_FLAGS_HIGH, 0);
      check("flags high", rd, {29'h0, irqFlagHi, 1'b0});
    end
    apb(1'b0, 16'hfe07, 0);
    check("unmapped err", {31'h0, err}, 1);
    check("unmapped data", rd, 0);
    window(40);
    check("osc bus rate", 32'(c), 10);
    lo = 32'(genClkOut);
    @(posedge sys_clk);
    check("gen osc toggle", lo ^ 32'(genClkOut), 1);
    apb(1'b1, IDX_CTRL, 32'h0000_0004);
    repeat (60) @(posedge sys_clk);
    window(240);
    check("pll bus rate", inr(c, 9, 11), 1);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, IDX_CTRL, 32'(m << CTRL_MODB_WAIT));
      pulse(0);
      repeat (8) @(posedge sys_clk);
      window(40);
      check("cpu in wait", 32'(c), 0);
      check("modA in wait", 32'(a), 10);
      check("modB in wait", 32'(b), 10 * m);
      pulse(2);
      repeat (8) @(posedge sys_clk);
    end
    apb(1'b1, IDX_INT_MASK, 3);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, IDX_INT_STATUS, 3);
      apb(1'b1, IDX_CTRL, s ? 32'h0000_0001 : 32'h0000_0002);
      pulse(1);
      repeat (4) @(posedge sys_clk);
      check("osc in stop", 32'(oscEnable), 32'(s));
      window(20);
      check("clocks in stop", 32'(c + a), 0);
      pulse(2);
      until_clk(1, 5000);
      check("recovery length", s ? inr(n, 4092, 4110) : inr(n, 28, 44), 1);
      repeat (4) @(posedge sys_clk);
      check("recover irq", 32'(irq), 1);
      apb(1'b1, IDX_INT_STATUS, 2);
      apb(1'b0, IDX_INT_STATUS, 0);
      check("status cleared", rd, 0);
      check("irq cleared", 32'(irq), 0);
    end
    for (int p = 3; p < 5; p++) begin
      pulse(p);
      check("resetOe again", 32'(extResetOe), 1);
      apb(1'b0, IDX_STATE, 0);
      check("state startup", rd, 32'(ST_STARTUP));
      until_clk(0, 5000);
      check("restart length", inr(n, 4080, 4106), 1);
    end
    summarize();
  end
endmodule
`default_nettype wire

// ### dv/sbcsc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbcsc_core_model (
  input wire logic sys_clk,
  input wire logic cpuClk,
  input wire logic modClkA,
  input wire logic modClkB,
  output var int cpuEdges,
  output var int modAEdges,
  output var int modBEdges
);
  logic [2:0] last;
  initial begin
    last = 3'b000;
    cpuEdges = 0;
    modAEdges = 0;
    modBEdges = 0;
  end
  // Edges are counted at sys_clk because the gated clocks are registers of that clock
  always @(posedge sys_clk) begin
    if (cpuClk === 1'b1 && last[0] === 1'b0) cpuEdges <= cpuEdges + 1;
    if (modClkA === 1'b1 && last[1] === 1'b0) modAEdges <= modAEdges + 1;
    if (modClkB === 1'b1 && last[2] === 1'b0) modBEdges <= modBEdges + 1;
    last <= {modClkB, modClkA, cpuClk};
  end
endmodule
`default_nettype wire
